// file: pkg/rzt_cfg.svh
// Function
// - read-only 8-bit remote temperature result
// - values are 8-bit two's complement degrees
// - result at 10h, reset 00h, not writable
// - result changes only after a conversion completes
// - remote hysteresis at 12h, reset 5Ch
// - remote setpoint at 13h, reset 61h
// - overtemp hysteresis at 22h, reset 5Ch
// - overtemp setpoint at 23h, reset 61h
// - interrupt held until host clears it
// - status set after fault-queue conversions over setpoint
// - mode bit: 1 interrupt, 0 comparator
`ifndef RZT_CFG_SVH
`define RZT_CFG_SVH

// command bytes of the device registers
`define RZT_CMD_RESULT 8'h10
`define RZT_CMD_HYST 8'h12
`define RZT_CMD_SET 8'h13
`define RZT_CMD_OHYST 8'h22
`define RZT_CMD_OSET 8'h23

// power-up values
`define RZT_RST_RESULT 8'h00
`define RZT_RST_HYST 8'h5C
`define RZT_RST_SET 8'h61
`define RZT_RST_OHYST 8'h5C
`define RZT_RST_OSET 8'h61

// fault queue depths for codes 00..11
`define RZT_FQ_D0 3'h1
`define RZT_FQ_D1 3'h2
`define RZT_FQ_D2 3'h4
`define RZT_FQ_D3 3'h6

// host-side apb register map
`define RZT_APB_CTRL 12'h000
`define RZT_APB_STAT 12'h004
`define RZT_CTRL_CMD_LSB 0
`define RZT_CTRL_WDATA_LSB 8
`define RZT_CTRL_WR_BIT 16
`define RZT_CTRL_RD_BIT 17
`define RZT_STAT_BUSY_BIT 8
`define RZT_STAT_DONE_BIT 9
`define RZT_STAT_INT_BIT 10
`define RZT_STAT_OVERTEMP_OUT_N_BIT 11

`endif

// file: pkg/rzt_pkg.sv
package rzt_pkg;

    typedef logic [7:0] rzt_temp_t;

    typedef enum logic [1:0] {
        RZT_IDLE = 2'b00,
        RZT_WAIT = 2'b01,
        RZT_DONE = 2'b10
    } rzt_hstate_t;

    typedef struct packed {
        rzt_temp_t result;
        rzt_temp_t hyst;
        rzt_temp_t setp;
        rzt_temp_t ohyst;
        rzt_temp_t osetp;
        logic zone;
        logic overtemp_out_n;
        logic [2:0] zone_cnt;
        logic [2:0] overtemp_out_n_cnt;
        logic int_pend;
        rzt_temp_t rdata;
        logic rvalid;
        logic int_oe;
        logic overtemp_out_n_oe;
    } rzt_dev_t;

    typedef struct packed {
        rzt_hstate_t st;
        rzt_temp_t cmd;
        rzt_temp_t wdata;
        logic wr;
        logic rd;
        rzt_temp_t last;
        logic done;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } rzt_host_t;

endpackage

// file: pkg/rzt_if.sv
`timescale 1ns/100ps
interface rzt_if (
    input wire logic pclk
);
    import rzt_pkg::*;
    rzt_temp_t cmd;
    rzt_temp_t wdata;
    logic wr;
    logic rd;
    rzt_temp_t rdata;
    logic rvalid;
    logic int_o;
    logic int_oe;
    logic overtemp_out_n_o;
    logic overtemp_out_n_oe;
    logic int_line;
    logic overtemp_out_n_line;

    // open-drain lines with pull-up
    assign int_line = int_oe ? int_o : 1'b1;
    assign overtemp_out_n_line = overtemp_out_n_oe ? overtemp_out_n_o : 1'b1;

    modport dev (input pclk, input cmd, input wdata, input wr, input rd,
        output rdata, output rvalid, output int_o, output int_oe, output overtemp_out_n_o, output overtemp_out_n_oe);
    modport host (input pclk, output cmd, output wdata, output wr, output rd,
        input rdata, input rvalid, input int_line, input overtemp_out_n_line);
endinterface

// file: rtl/rzt_dev.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "rzt_cfg.svh"
module rzt_dev
    import rzt_pkg::*;
(
    input wire logic presetn,
    rzt_if.dev link,
    input wire logic conv_valid,
    input wire rzt_temp_t conv_temp,
    input wire logic mode_int,
    input wire logic [1:0] fault_queue,
    input wire logic int_mask,
    output logic remote_status,
    output logic overtemp_status
);

    rzt_dev_t r;
    rzt_dev_t next_r;

    // signed compare, one degree per lsb
    function automatic logic above(input rzt_temp_t a, input rzt_temp_t b);
        above = $signed(a) > $signed(b);
    endfunction

    function automatic logic [2:0] fq_depth(input logic [1:0] code);
        case (code)
            2'b00: fq_depth = `RZT_FQ_D0;
            2'b01: fq_depth = `RZT_FQ_D1;
            2'b10: fq_depth = `RZT_FQ_D2;
            default: fq_depth = `RZT_FQ_D3;
        endcase
    endfunction

    function automatic logic [2:0] bump(input logic [2:0] c, input logic [2:0] lim);
        bump = (c < lim) ? c + 3'h1 : c;
    endfunction

    // next state: register writes, conversions, alarm tracking
    always_comb begin
        logic [2:0] lim;
        logic zone_change;
        next_r = r;
        lim = fq_depth(fault_queue);
        zone_change = 1'b0;
        next_r.rvalid = 1'b0;
        if (link.wr) begin
            case (link.cmd)
                `RZT_CMD_HYST: next_r.hyst = link.wdata;
                `RZT_CMD_SET: next_r.setp = link.wdata;
                `RZT_CMD_OHYST: next_r.ohyst = link.wdata;
                `RZT_CMD_OSET: next_r.osetp = link.wdata;
                default: next_r.hyst = next_r.hyst; // result and unknown bytes are dropped
            endcase
        end
        if (link.rd) begin
            next_r.rvalid = 1'b1;
            case (link.cmd)
                `RZT_CMD_RESULT: next_r.rdata = r.result;
                `RZT_CMD_HYST: next_r.rdata = r.hyst;
                `RZT_CMD_SET: next_r.rdata = r.setp;
                `RZT_CMD_OHYST: next_r.rdata = r.ohyst;
                `RZT_CMD_OSET: next_r.rdata = r.osetp;
                default: next_r.rdata = 8'h00;
            endcase
            next_r.int_pend = 1'b0; // a host read is the clearing action
        end
        // thresholds compare against the fresh sample, not the stored one
        if (conv_valid) begin
            next_r.result = conv_temp;
            if (!r.zone) begin
                next_r.zone_cnt = above(conv_temp, r.setp) ? bump(r.zone_cnt, lim) : 3'h0;
                if (next_r.zone_cnt >= lim) begin
                    next_r.zone = 1'b1;
                    next_r.zone_cnt = 3'h0;
                    zone_change = 1'b1;
                end
            end else begin
                next_r.zone_cnt = above(r.hyst, conv_temp) ? bump(r.zone_cnt, lim) : 3'h0;
                if (next_r.zone_cnt >= lim) begin
                    next_r.zone = 1'b0;
                    next_r.zone_cnt = 3'h0;
                    zone_change = 1'b1;
                end
            end
            if (!r.overtemp_out_n) begin
                next_r.overtemp_out_n_cnt = above(conv_temp, r.osetp) ? bump(r.overtemp_out_n_cnt, lim) : 3'h0;
                if (next_r.overtemp_out_n_cnt >= lim) begin
                    next_r.overtemp_out_n = 1'b1;
                    next_r.overtemp_out_n_cnt = 3'h0;
                end
            end else begin
                next_r.overtemp_out_n_cnt = above(r.ohyst, conv_temp) ? bump(r.overtemp_out_n_cnt, lim) : 3'h0;
                if (next_r.overtemp_out_n_cnt >= lim) begin
                    next_r.overtemp_out_n = 1'b0;
                    next_r.overtemp_out_n_cnt = 3'h0;
                end
            end
        end
        // set after clear so a same-cycle event is never lost
        if (zone_change) begin
            next_r.int_pend = 1'b1;
        end
        // mode picks latched event or live comparator level
        next_r.int_oe = !int_mask && (mode_int ? next_r.int_pend : next_r.zone);
        next_r.overtemp_out_n_oe = next_r.overtemp_out_n;
    end

    always_ff @(posedge link.pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.result <= `RZT_RST_RESULT;
            r.hyst <= `RZT_RST_HYST;
            r.setp <= `RZT_RST_SET;
            r.ohyst <= `RZT_RST_OHYST;
            r.osetp <= `RZT_RST_OSET;
        end else begin
            r <= next_r;
        end
    end

    assign link.rdata = r.rdata;
    assign link.rvalid = r.rvalid;
    assign link.int_o = 1'b0; // open drain only ever pulls low
    assign link.int_oe = r.int_oe;
    assign link.overtemp_out_n_o = 1'b0;
    assign link.overtemp_out_n_oe = r.overtemp_out_n_oe;
    assign remote_status = r.zone;
    assign overtemp_status = r.overtemp_out_n;

endmodule

// file: rtl/rzt_host.sv
`timescale 1ns/100ps
`include "rzt_cfg.svh"
module rzt_host
    import rzt_pkg::*;
(
    input wire logic presetn,
    rzt_if.host link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    rzt_host_t h;
    rzt_host_t next_h;

    // host-side order port; one device access at a time
    always_comb begin
        logic setup;
        logic acc;
        next_h = h;
        setup = psel && !penable;
        acc = psel && penable && h.pready;
        next_h.wr = 1'b0;
        next_h.rd = 1'b0;
        next_h.pready = setup;
        next_h.pslverr = 1'b0;
        if (setup) begin
            next_h.prdata = 32'h0000_0000;
            case (paddr)
                `RZT_APB_CTRL: next_h.prdata = {16'h0000, h.wdata, h.cmd};
                `RZT_APB_STAT: begin
                    next_h.prdata[7:0] = h.last;
                    next_h.prdata[`RZT_STAT_BUSY_BIT] = (h.st != RZT_IDLE);
                    next_h.prdata[`RZT_STAT_DONE_BIT] = h.done;
                    next_h.prdata[`RZT_STAT_INT_BIT] = !link.int_line;
                    next_h.prdata[`RZT_STAT_OVERTEMP_OUT_N_BIT] = !link.overtemp_out_n_line;
                end
                default: next_h.pslverr = 1'b1;
            endcase
        end
        case (h.st)
            RZT_IDLE: begin
                // orders arriving while busy are dropped; software polls busy first
                if (acc && pwrite && paddr == `RZT_APB_CTRL) begin
                    next_h.cmd = pwdata[`RZT_CTRL_CMD_LSB +: 8];
                    next_h.wdata = pwdata[`RZT_CTRL_WDATA_LSB +: 8];
                    if (pwdata[`RZT_CTRL_RD_BIT]) begin
                        next_h.rd = 1'b1;
                        next_h.st = RZT_WAIT;
                    end else if (pwdata[`RZT_CTRL_WR_BIT]) begin
                        next_h.wr = 1'b1; // writes to 10h are sent but the device drops them
                        next_h.st = RZT_DONE;
                    end
                end
            end
            RZT_WAIT: begin
                if (link.rvalid) begin
                    next_h.last = link.rdata;
                    next_h.st = RZT_DONE;
                end
            end
            RZT_DONE: begin
                next_h.st = RZT_IDLE;
            end
            default: next_h.st = RZT_IDLE;
        endcase
        // write-one-to-clear done; completion in the same cycle wins
        if (acc && pwrite && paddr == `RZT_APB_STAT && pwdata[`RZT_STAT_DONE_BIT]) begin
            next_h.done = 1'b0;
        end
        if (h.st == RZT_DONE) begin
            next_h.done = 1'b1;
        end
    end

    always_ff @(posedge link.pclk or negedge presetn) begin
        if (!presetn) begin
            h <= '0;
            h.st <= RZT_IDLE;
        end else begin
            h <= next_h;
        end
    end

    assign link.cmd = h.cmd;
    assign link.wdata = h.wdata;
    assign link.wr = h.wr;
    assign link.rd = h.rd;
    assign prdata = h.prdata;
    assign pready = h.pready;
    assign pslverr = h.pslverr;

endmodule

// file: sim/rzt_sva.sv
`timescale 1ns/100ps
`include "rzt_cfg.svh"
module rzt_sva
    import rzt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire rzt_temp_t cmd,
    input wire logic wr,
    input wire logic rd,
    input wire rzt_temp_t rdata,
    input wire logic rvalid,
    input wire logic int_oe,
    input wire logic overtemp_out_n_oe,
    input wire logic int_line,
    input wire logic overtemp_out_n_line
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // link reads get one answer pulse, next cycle
    read_answer_a: assert property (rd |=> rvalid ##1 !rvalid) else $error("no read answer");
    answer_cause_a: assert property (rvalid |-> $past(rd)) else $error("answer without read");
    rd_pulse_a: assert property (rd |=> !rd) else $error("read held");
    unknown_zero_a: assert property (
        rd && !(cmd inside {`RZT_CMD_RESULT, `RZT_CMD_HYST, `RZT_CMD_SET, `RZT_CMD_OHYST, `RZT_CMD_OSET})
        |=> rdata == 8'h00) else $error("unknown byte not zero");
    one_request_a: assert property (!(wr && rd)) else $error("read and write together");
    int_pull_a: assert property (int_oe |-> !int_line) else $error("int line not low");
    overtemp_out_n_pull_a: assert property (overtemp_out_n_oe |-> !overtemp_out_n_line) else $error("overtemp_out_n line not low");
    // read data only moves with its answer pulse; a write never gets an answer
    rdata_hold_a: assert property (!rvalid |-> $stable(rdata)) else $error("read data moved");
    write_silent_a: assert property (wr |=> !rvalid) else $error("write answered");
endmodule

// file: sim/rzt_bench.sv
`timescale 1ns/100ps
`include "rzt_cfg.svh"
module rzt_bench
    import rzt_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, conv_valid, mode_int, int_mask, rstat, ostat;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [1:0] fault_queue;
    rzt_temp_t conv_temp, rb;
    int mismatches, comparisons, seed, mz, mc, nz, nc, dp;
    int mdl [int];

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    rzt_if i_link (.pclk(pclk));
    rzt_dev i_rzt_dev (.presetn(presetn), .link(i_link.dev), .conv_valid(conv_valid), .conv_temp(conv_temp),
        .mode_int(mode_int), .fault_queue(fault_queue), .int_mask(int_mask), .remote_status(rstat),
        .overtemp_status(ostat));
    rzt_host i_rzt_host (.presetn(presetn), .link(i_link.host), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    rzt_sva i_rzt_sva (.pclk(pclk), .presetn(presetn), .cmd(i_link.cmd), .wr(i_link.wr), .rd(i_link.rd),
        .rdata(i_link.rdata), .rvalid(i_link.rvalid), .int_oe(i_link.int_oe), .overtemp_out_n_oe(i_link.overtemp_out_n_oe),
        .int_line(i_link.int_line), .overtemp_out_n_line(i_link.overtemp_out_n_line));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task conclude;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // one apb transfer; pready and prdata are taken at the same edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
            if (n > 50) begin
                mismatches++;
                conclude();
            end
        end while (!pready);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // link byte operation; done is polled with a bound, then cleared
    task op(input logic rdop, input rzt_temp_t c, input rzt_temp_t d);
        apb(1'b1, `RZT_APB_CTRL, {14'h0, rdop, ~rdop, d, c});
        for (int n = 0; n < 40; n++) begin
            apb(1'b0, `RZT_APB_STAT, '0);
            if (n == 0 && rdop) chk(r[`RZT_STAT_BUSY_BIT], 1'b1);
            if (r[`RZT_STAT_DONE_BIT]) break;
            if (n == 39) begin
                mismatches++;
                conclude();
            end
        end
        chk(r[`RZT_STAT_BUSY_BIT], 1'b0);
        rb = r[7:0];
        apb(1'b1, `RZT_APB_STAT, 32'h00000200);
    endtask

    task rdm(input rzt_temp_t c);
        op(1'b1, c, 8'h00);
        chk(rb, mdl.exists(c) ? mdl[c] : 0);
    endtask

    // a write to the result byte is never stored by the model; conv stores each new result
    task setr(input rzt_temp_t c, input rzt_temp_t v);
        op(1'b0, c, v);
        if (c != `RZT_CMD_RESULT) mdl[c] = v;
    endtask

    // signed compare, n consecutive samples toggle the status
    function automatic void step(ref int s, ref int n, input int set, input int hy, input int t);
        logic signed [7:0] a, b, c;
        a = 8'(set);
        b = 8'(hy);
        c = 8'(t);
        n = (!s && c > a || s && c < b) ? n + 1 : 0;
        if (n >= dp) begin
            s = !s;
            n = 0;
        end
    endfunction

    task conv(input rzt_temp_t t);
        @(posedge pclk);
        conv_valid <= 1'b1;
        conv_temp <= t;
        @(posedge pclk);
        conv_valid <= 1'b0;
        mdl[`RZT_CMD_RESULT] = t;
        step(mz, nz, mdl[`RZT_CMD_SET], mdl[`RZT_CMD_HYST], t);
        step(mc, nc, mdl[`RZT_CMD_OSET], mdl[`RZT_CMD_OHYST], t);
        @(posedge pclk);
        chk(rstat, mz);
        chk(ostat, mc);
    endtask

    task stat(input logic x);
        apb(1'b0, `RZT_APB_STAT, '0);
        chk(r[`RZT_STAT_INT_BIT], x);
        chk(r[`RZT_STAT_OVERTEMP_OUT_N_BIT], mc);
    endtask

    initial begin
        seed = 32'h39C90A33;
        {presetn, psel, penable, pwrite, conv_valid, mode_int, int_mask} = '0;
        paddr = '0;
        pwdata = '0;
        fault_queue = '0;
        conv_temp = '0;
        {mismatches, comparisons, mz, mc, nz, nc} = '0;
        dp = 1;
        mdl = '{`RZT_CMD_RESULT: `RZT_RST_RESULT, `RZT_CMD_HYST: `RZT_RST_HYST, `RZT_CMD_SET: `RZT_RST_SET,
            `RZT_CMD_OHYST: `RZT_RST_OHYST, `RZT_CMD_OSET: `RZT_RST_OSET};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        // power-up values, an unused byte, an unmapped apb word
        foreach (mdl[c]) rdm(8'(c));
        rdm(8'h11);
        apb(1'b0, 12'h008, '0);
        chk(e, 1'b1);
        foreach (mdl[c]) begin
            setr(8'(c), 8'($random(seed)));
            rdm(8'(c));
        end
        conv(8'hE7);
        rdm(8'h10);
        // negative hysteresis tests the signed compare
        setr(8'h13, 8'h05);
        setr(8'h12, 8'hFB);
        setr(8'h23, 8'h0A);
        setr(8'h22, 8'h00);
        for (int q = 0; q < 4; q++) begin
            fault_queue <= 2'(q);
            dp = q == 0 ? 1 : q * 2;
            repeat (6) conv(8'($random(seed)));
            repeat (dp) conv(8'h30);
            repeat (dp) conv(8'hF0);
        end
        // interrupt mode holds the line until a link read
        fault_queue <= 2'b00;
        dp = 1;
        mode_int <= 1'b1;
        rdm(8'h10);
        conv(8'h30);
        stat(1'b1);
        stat(1'b1);
        rdm(8'h10);
        stat(1'b0);
        mode_int <= 1'b0;
        stat(1'b1);
        int_mask <= 1'b1;
        stat(1'b0);
        // the order word reads back the last command byte and write data
        apb(1'b0, `RZT_APB_CTRL, '0);
        chk(r, {16'h0000, 8'h00, `RZT_CMD_RESULT});
        conclude();
    end
endmodule
